// ===== bench/sild_far_model.sv
// far-side model: low register file and data memory of the core
`timescale 1ns/1ps
module sild_far_model (
  // clock
  input wire logic ref_clk,
  // register file
  input wire logic [2:0] base_reg,
  input wire logic [2:0] offset_reg,
  input wire logic [2:0] src_reg,
  output logic [31:0] base_data,
  output logic [31:0] offset_data,
  output logic [31:0] src_data,
  input wire logic wb_en,
  input wire logic [2:0] wb_reg,
  input wire logic [31:0] wb_data,
  // data memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic [31:0] mem_rdata
);
  logic [31:0] rf [8];
  logic [31:0] mem [16];
  logic [31:0] last;
  assign base_data = rf[base_reg];
  assign offset_data = rf[offset_reg];
  assign src_data = rf[src_reg];
  // data only in the access cycle, a changing pattern otherwise
  assign mem_rdata = mem_req ? mem[mem_addr[5:2]] : ~last;
  initial begin
    last = 32'h0;
    for (int k = 0; k < 16; k++) mem[k] = 32'h0;
    for (int k = 0; k < 8; k++) rf[k] = 32'h0;
  end
  always @(posedge ref_clk) begin
    last <= mem_rdata;
    if (wb_en) rf[wb_reg] <= wb_data;
    if (mem_req && mem_we)
      for (int b = 0; b < 4; b++)
        if (mem_be[b]) mem[mem_addr[5:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
  end
endmodule

// ===== bench/tb_top.sv
// self-checking testbench of the short load/store decoder
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, arst_n, insn_valid, insn_ready, insn_illegal, wb_en, mem_req, mem_we;
  logic [15:0] insn;
  logic [31:0] insn_addr, base_data, offset_data, src_data, wb_data;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [2:0] base_reg, offset_reg, src_reg, wb_reg;
  logic [3:0] mem_be;
  int n_mismatch = 0;
  int check_count = 0;
  sild_decode uut (.ref_clk, .arst_n, .insn_valid, .insn, .insn_addr, .insn_ready,
    .insn_illegal, .base_reg, .offset_reg, .src_reg, .base_data, .offset_data,
    .src_data, .wb_en, .wb_reg, .wb_data, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_be, .mem_rdata);
  sild_far_model mdl (.ref_clk, .base_reg, .offset_reg, .src_reg, .base_data,
    .offset_data, .src_data, .wb_en, .wb_reg, .wb_data, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_be, .mem_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one transfer: address, store data or load result, and spacing
  task automatic op(input logic [15:0] i, input logic [31:0] pc, input logic [31:0] a,
    input logic ld, input logic [3:0] be, input logic [31:0] v);
    logic [2:0] rd;
    rd = (i[15:11] == 5'h09) ? i[10:8] : i[2:0];
    @(posedge ref_clk);
    insn_valid <= 1'b1;
    insn <= i;
    insn_addr <= pc;
    @(posedge ref_clk);
    insn_valid <= 1'b0;
    #1;
    chk(mem_req, 1'h1);
    chk(mem_we, !ld);
    chk(mem_addr, a);
    chk(insn_ready, 1'h0);
    if (!ld) begin
      chk(mem_be, be);
      chk(mem_wdata, v);
    end
    @(posedge ref_clk);
    #1;
    chk(wb_en, ld);
    chk(insn_ready, !ld);
    if (ld) begin
      chk(wb_reg, rd);
      chk(wb_data, v);
      @(posedge ref_clk);
      #1;
      chk(insn_ready, 1'h1);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regofs();
    mdl.rf[2] = 32'h20;
    mdl.rf[6] = 32'h4;
    mdl.rf[3] = 32'h11223380;
    op(16'h5193, 32'h0, 32'h24, 1'h0, 4'hf, 32'h11223380);
    mdl.rf[3] = 32'hc7;
    op(16'h5593, 32'h0, 32'h24, 1'h0, 4'h1, 32'hc7c7c7c7);
    op(16'h5993, 32'h0, 32'h24, 1'h1, 4'h0, 32'h112233c7);
    op(16'h5d93, 32'h0, 32'h24, 1'h1, 4'h0, 32'hc7);
    $display("t_regofs done");
  endtask
  task automatic t_signext();
    mdl.rf[7] = 32'h40;
    mdl.rf[1] = 32'h2;
    mdl.rf[4] = 32'hdead8001;
    op(16'h527c, 32'h0, 32'h42, 1'h0, 4'hc, 32'h80018001);
    op(16'h567c, 32'h0, 32'h42, 1'h1, 4'h0, 32'h8001);
    op(16'h5a7c, 32'h0, 32'h42, 1'h1, 4'h0, 32'h1);
    op(16'h5e7c, 32'h0, 32'h42, 1'h1, 4'h0, 32'hffff8001);
    mdl.rf[1] = 32'h3;
    op(16'h5a7c, 32'h0, 32'h43, 1'h1, 4'h0, 32'hffffff80);
    $display("t_signext done");
  endtask
  task automatic t_immofs();
    mdl.rf[5] = 32'h100;
    mdl.rf[2] = 32'hcafe0123;
    op(16'h67ea, 32'h0, 32'h17c, 1'h0, 4'hf, 32'hcafe0123);
    op(16'h6fea, 32'h0, 32'h17c, 1'h1, 4'h0, 32'hcafe0123);
    op(16'h77ea, 32'h0, 32'h11f, 1'h0, 4'h8, 32'h23232323);
    op(16'h7fea, 32'h0, 32'h11f, 1'h1, 4'h0, 32'h23);
    $display("t_immofs done");
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    insn_valid <= 1'b1;
    insn <= 16'h6fea;
    @(posedge ref_clk);
    insn_valid <= 1'b0;
    arst_n <= 1'b0;
    #1;
    chk(mem_req, 1'h0);
    chk(wb_en, 1'h0);
    chk(insn_ready, 1'h1);
    chk(mem_addr, 32'h0);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    op(16'h6fea, 32'h0, 32'h17c, 1'h1, 4'h0, 32'hcafe0123);
    $display("t_reset done");
  endtask
  task automatic t_immhalf();
    mdl.rf[0] = 32'h200;
    mdl.rf[1] = 32'h7777abcd;
    op(16'h87c1, 32'h0, 32'h23e, 1'h0, 4'hc, 32'habcdabcd);
    op(16'h8fc1, 32'h0, 32'h23e, 1'h1, 4'h0, 32'habcd);
    $display("t_immhalf done");
  endtask
  task automatic t_pcrel();
    mdl.mem[0] = 32'h5a5aa5a5;
    mdl.mem[3] = 32'h3c3c3c3c;
    op(16'h4dff, 32'h1002, 32'h1400, 1'h1, 4'h0, 32'h5a5aa5a5);
    op(16'h4d01, 32'h1004, 32'h100c, 1'h1, 4'h0, 32'h3c3c3c3c);
    $display("t_pcrel done");
  endtask
  task automatic t_illegal();
    @(posedge ref_clk);
    insn_valid <= 1'b1;
    insn <= 16'h4040;
    @(posedge ref_clk);
    insn_valid <= 1'b0;
    #1;
    chk(insn_illegal, 1'h1);
    chk(mem_req, 1'h0);
    @(posedge ref_clk);
    #1;
    chk(insn_illegal, 1'h0);
    $display("t_illegal done");
  endtask
  initial begin
    arst_n = 1'b0;
    insn_valid = 1'b0;
    insn = 16'h0;
    insn_addr = 32'h0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(insn_ready, 1'h1);
    chk(mem_req, 1'h0);
    t_regofs();
    t_signext();
    t_immofs();
    t_reset();
    t_immhalf();
    t_pcrel();
    t_illegal();
    finish_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule

// ===== hw/sild_decode.sv
// short load/store decoder with address generation and data transfer
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module sild_decode
  import sild_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // instruction issue
  input wire logic insn_valid,
  input wire logic [15:0] insn,
  input wire logic [31:0] insn_addr,
  output logic insn_ready,
  output logic insn_illegal,
  // register file read
  output logic [2:0] base_reg,
  output logic [2:0] offset_reg,
  output logic [2:0] src_reg,
  input wire logic [31:0] base_data,
  input wire logic [31:0] offset_data,
  input wire logic [31:0] src_data,
  // register file write
  output logic wb_en,
  output logic [2:0] wb_reg,
  output logic [31:0] wb_data,
  // data memory
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic [31:0] mem_rdata
);
  // ****************************************
  // field decode
  // ****************************************
  sild_op_t op;
  logic [4:0] imm5_offset_field;
  logic [7:0] imm8_word_field;
  logic [31:0] ofs;
  logic [31:0] base;
  logic [2:0] rd;
  logic is_pcrel;
  logic [1:0] lb;
  logic store_byte_op;
  logic load_byte_op;
  logic store_half_op;
  logic load_half_op;
  logic load_signed_byte_op;
  logic load_signed_half_op;

  assign imm5_offset_field = insn[SILD_IMM5_LSB +: 5];
  assign imm8_word_field = insn[7:0];
  assign base_reg = insn[SILD_BASE_LSB +: 3];
  assign offset_reg = insn[SILD_OFS_LSB +: 3];
  assign src_reg = rd;
  assign is_pcrel = (insn[15:11] == SILD_OP_PCREL);

  always_comb begin
    op = SILD_NONE;
    ofs = 32'h0000_0000;
    base = base_data;
    rd = insn[SILD_RD_LSB +: 3];
    lb = {insn[SILD_FMT78_L_BIT], insn[SILD_FMT78_B_BIT]};
    if (is_pcrel) begin
      op = SILD_LOAD_WORD;
      rd = insn[SILD_RD8_LSB +: 3];
      // RULE16 RULE17 pc base aligned
      base = (insn_addr + SILD_PC_AHEAD) & ~32'h0000_0002;
      ofs = {24'h000000, imm8_word_field} << SILD_WORD_SHIFT;
    end else if (insn[15:12] == SILD_OP_REGOFS) begin
      // RULE1 register offset sum
      ofs = offset_data;
      if (!insn[SILD_FMT7_SEL_BIT]) begin
        // RULE2 register format ops
        case (lb)
          2'b00: op = SILD_STORE_WORD;
          2'b01: op = SILD_STORE_BYTE;
          2'b10: op = SILD_LOAD_WORD;
          default: op = SILD_LOAD_BYTE;
        endcase
      end else begin
        // RULE5 sign-extend format ops
        case (lb)
          2'b00: op = SILD_STORE_HALF;
          2'b01: op = SILD_LOAD_HALF;
          2'b10: op = SILD_LOAD_SBYTE;
          default: op = SILD_LOAD_SHALF;
        endcase
      end
    end else if (insn[15:13] == SILD_OP_IMMWB) begin
      // RULE12 immediate format ops
      case ({insn[SILD_FMT9_L_BIT], insn[SILD_FMT9_B_BIT]})
        2'b00: op = SILD_STORE_WORD;
        2'b10: op = SILD_LOAD_WORD;
        2'b01: op = SILD_STORE_BYTE;
        default: op = SILD_LOAD_BYTE;
      endcase
      // RULE10 RULE11 offset scaling
      if (insn[SILD_FMT9_B_BIT]) begin
        ofs = {27'h0000000, imm5_offset_field};
      end else begin
        ofs = {27'h0000000, imm5_offset_field} << SILD_WORD_SHIFT;
      end
    end else if (insn[15:12] == SILD_OP_IMMHALF) begin
      // RULE13 RULE14 halfword immediate
      op = insn[SILD_FMT10_L_BIT] ? SILD_LOAD_HALF : SILD_STORE_HALF;
      ofs = {27'h0000000, imm5_offset_field} << SILD_HALF_SHIFT;
    end
  end

  assign store_byte_op = (op == SILD_STORE_BYTE);
  assign load_byte_op = (op == SILD_LOAD_BYTE);
  assign store_half_op = (op == SILD_STORE_HALF);
  assign load_half_op = (op == SILD_LOAD_HALF);
  assign load_signed_byte_op = (op == SILD_LOAD_SBYTE);
  assign load_signed_half_op = (op == SILD_LOAD_SHALF);

  // ****************************************
  // access sequencer
  // ****************************************
  sild_state_t state;
  sild_state_t next_state;
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [3:0] be;
  logic [3:0] next_be;
  logic we;
  logic next_we;
  logic [2:0] dst;
  logic [2:0] next_dst;
  sild_size_t size;
  sild_size_t next_size;
  logic sgn;
  logic next_sgn;
  logic illegal;
  logic next_illegal;
  logic [31:0] ea;
  logic [31:0] ext_data;

  assign ea = base + ofs;
  assign insn_ready = (state == SILD_IDLE);

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_wdata = wdata;
    next_be = be;
    next_we = we;
    next_dst = dst;
    next_size = size;
    next_sgn = sgn;
    next_illegal = 1'b0;
    case (state)
      SILD_IDLE: begin
        if (insn_valid && op == SILD_NONE) begin
          next_illegal = 1'b1;
        end else if (insn_valid) begin
          next_state = SILD_ACCESS;
          next_addr = ea;
          next_dst = rd;
          next_we = !(op == SILD_LOAD_WORD || load_byte_op || load_half_op ||
                      load_signed_byte_op || load_signed_half_op);
          next_sgn = load_signed_byte_op || load_signed_half_op;
          next_size = SILD_SZ_WORD;
          next_be = 4'hf;
          next_wdata = src_data;
          if (store_byte_op || load_byte_op || load_signed_byte_op) begin
            next_size = SILD_SZ_BYTE;
            // RULE3 single byte lane
            next_be = 4'h1 << ea[1:0];
            next_wdata = {4{src_data[7:0]}};
          end else if (store_half_op || load_half_op || load_signed_half_op) begin
            next_size = SILD_SZ_HALF;
            // RULE6 halfword lanes picked by address bit 1
            next_be = ea[1] ? 4'hc : 4'h3;
            next_wdata = {2{src_data[15:0]}};
          end
        end
      end
      // RULE15 store one cycle, load two
      SILD_ACCESS: begin
        next_state = we ? SILD_IDLE : SILD_WRITEBACK;
      end
      SILD_WRITEBACK: begin
        next_state = SILD_IDLE;
      end
      default: begin
        next_state = SILD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SILD_IDLE;
      addr <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
      be <= 4'h0;
      we <= 1'b0;
      dst <= 3'h0;
      size <= SILD_SZ_WORD;
      sgn <= 1'b0;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      wdata <= next_wdata;
      be <= next_be;
      we <= next_we;
      dst <= next_dst;
      size <= next_size;
      sgn <= next_sgn;
      illegal <= next_illegal;
    end
  end

  // ****************************************
  // memory and writeback
  // ****************************************
  logic [31:0] load_q;
  logic [31:0] next_load_q;

  sild_load_extend u_ext (
    .rdata(mem_rdata),
    .lane(addr[1:0]),
    .size(size),
    .signed_load(sgn),
    .result(ext_data)
  );

  always_comb begin
    next_load_q = load_q;
    if (state == SILD_ACCESS && !we) begin
      next_load_q = ext_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_q <= 32'h0000_0000;
    end else begin
      load_q <= next_load_q;
    end
  end

  assign mem_req = (state == SILD_ACCESS);
  assign mem_we = mem_req & we;
  assign mem_addr = addr;
  assign mem_wdata = wdata;
  assign mem_be = mem_req ? be : 4'h0;
  assign wb_en = (state == SILD_WRITEBACK);
  assign wb_reg = dst;
  assign wb_data = load_q;
  assign insn_illegal = illegal;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_load_issue;
    insn_ready && insn_valid && (op == SILD_LOAD_WORD || load_half_op);
  endsequence
  sequence s_load_done;
    mem_req && !mem_we ##1 wb_en;
  endsequence

  // RULE15 load cycles
  a_load_two_cycles: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_load_issue |=> s_load_done) else $error("load did not write back after two cycles");
  // RULE15 store cycles
  a_store_one_cycle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mem_we |=> insn_ready && !wb_en) else $error("store did not finish in one cycle");
  // RULE1 register sum
  a_regofs_addr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    insn_ready && insn_valid && insn[15:12] == SILD_OP_REGOFS
    |=> mem_addr == $past(base_data) + $past(offset_data))
    else $error("register offset address wrong");
  // RULE3 byte lane
  a_byte_store_lane: assert property (@(posedge ref_clk) disable iff (!arst_n)
    insn_ready && insn_valid && store_byte_op
    |=> $countones(mem_be) == 1 && mem_wdata[7:0] == $past(src_data[7:0]))
    else $error("byte store lanes wrong");
  // RULE6 half lanes
  a_half_store_lane: assert property (@(posedge ref_clk) disable iff (!arst_n)
    insn_ready && insn_valid && store_half_op
    |=> $countones(mem_be) == 2 && mem_wdata[15:0] == $past(src_data[15:0]))
    else $error("halfword store lanes wrong");
  // RULE11 word scaling
  a_imm_word_scale: assert property (@(posedge ref_clk) disable iff (!arst_n)
    insn_ready && insn_valid && insn[15:13] == SILD_OP_IMMWB && !insn[SILD_FMT9_B_BIT]
    |=> mem_addr == $past(base_data) + {$past(imm5_offset_field), 2'h0})
    else $error("word immediate offset not scaled");
  // RULE16 pc alignment
  a_pcrel_align: assert property (@(posedge ref_clk) disable iff (!arst_n)
    insn_ready && insn_valid && is_pcrel |=> mem_addr[1:0] == ($past(insn_addr[1:0]) & 2'h1))
    else $error("pc-relative address misaligned");
  // RULE8 sign copy
  a_sbyte_extend: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mem_req && sgn && size == SILD_SZ_BYTE
    |=> wb_en && wb_data[31:8] == {24{wb_data[7]}})
    else $error("signed byte not extended");
  // RULE7 zero upper
  a_uhalf_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mem_req && !mem_we && !sgn && size == SILD_SZ_HALF
    |=> wb_en && wb_data[31:16] == 16'h0000)
    else $error("unsigned halfword upper bits not zero");
endmodule

// ===== hw/sild_load_extend.sv
// load data lane select and extension
`timescale 1ns/1ps
module sild_load_extend
  import sild_pkg::*;
(
  // request
  input wire logic [31:0] rdata,
  input wire logic [1:0] lane,
  input wire sild_size_t size,
  input wire logic signed_load,
  // result
  output logic [31:0] result
);
  logic [7:0] byte_val;
  logic [15:0] half_val;
  always_comb begin
    byte_val = rdata[8*lane +: 8];
    half_val = lane[1] ? rdata[31:16] : rdata[15:0];
    result = rdata;
    case (size)
      // RULE4 RULE8 byte extension
      SILD_SZ_BYTE: begin
        result = {{24{signed_load & byte_val[7]}}, byte_val};
      end
      // RULE7 RULE9 RULE14 halfword extension
      SILD_SZ_HALF: begin
        result = {{16{signed_load & half_val[15]}}, half_val};
      end
      default: begin
        result = rdata;
      end
    endcase
  end
endmodule

// ===== hw/sild_pkg.sv
// constants and types of the short load/store decoder
// Notes on behaviour
// RULE1: register-offset address is base register plus offset register, low registers 0-7.
// RULE2: register-offset load and byte flags: 00 word store, 01 byte store, 10/11 loads.
// RULE3: byte store writes only the low byte of the source, one lane enabled.
// RULE4: unsigned byte load puts byte in bits 7:0 and clears upper 24 bits.
// RULE5: sign-extend format opcodes: 00 half store, 01 half load, 10 sbyte, 11 shalf.
// RULE6: halfword store writes only source bits 15:0 at base plus offset.
// RULE7: unsigned halfword load fills bits 15:0 and zeroes bits 31:16.
// RULE8: signed byte load copies loaded bit 7 into bits 31:8.
// RULE9: signed halfword load copies loaded bit 15 into bits 31:16.
// RULE10: immediate byte accesses add the unscaled 5-bit field to the base.
// RULE11: immediate word accesses shift the 5-bit field left by two.
// RULE12: immediate format flags: 00 word store, 10 word load, 01 byte store, 11 byte load.
// RULE13: immediate halfword format shifts the 5-bit field left by one.
// RULE14: immediate halfword: load flag 0 stores low 16 bits, 1 loads zero-extended.
// RULE15: each access takes the same cycles as its full-width equivalent.
// RULE16: pc-relative load forces pc bit 1 to zero before adding offset.
// RULE17: pc-relative base is instruction address plus 4, 8-bit field scaled by four.
package sild_pkg;
  // ****************************************
  // instruction field positions
  // ****************************************
  localparam int SILD_RD_LSB = 0;
  localparam int SILD_BASE_LSB = 3;
  localparam int SILD_OFS_LSB = 6;
  localparam int SILD_IMM5_LSB = 6;
  localparam int SILD_RD8_LSB = 8;
  localparam int SILD_FMT9_B_BIT = 12;
  localparam int SILD_FMT9_L_BIT = 11;
  localparam int SILD_FMT78_L_BIT = 11;
  localparam int SILD_FMT78_B_BIT = 10;
  localparam int SILD_FMT7_SEL_BIT = 9;
  localparam int SILD_FMT10_L_BIT = 11;
  // ****************************************
  // format opcode patterns
  // ****************************************
  localparam logic [4:0] SILD_OP_PCREL = 5'h09;
  localparam logic [3:0] SILD_OP_REGOFS = 4'h5;
  localparam logic [2:0] SILD_OP_IMMWB = 3'h3;
  localparam logic [3:0] SILD_OP_IMMHALF = 4'h8;
  // ****************************************
  // address and timing constants
  // ****************************************
  localparam logic [31:0] SILD_PC_AHEAD = 32'h0000_0004;
  localparam int SILD_WORD_SHIFT = 2;
  localparam int SILD_HALF_SHIFT = 1;
  localparam logic [1:0] SILD_STORE_CYCLES = 2'h1;
  localparam logic [1:0] SILD_LOAD_CYCLES = 2'h2;
  // ****************************************
  // access size and operations
  // ****************************************
  typedef enum logic [1:0] {
    SILD_SZ_BYTE = 2'h0,
    SILD_SZ_HALF = 2'h1,
    SILD_SZ_WORD = 2'h2
  } sild_size_t;
  typedef enum logic [3:0] {
    SILD_NONE = 4'h0,
    SILD_STORE_WORD = 4'h1,
    SILD_STORE_BYTE = 4'h2,
    SILD_LOAD_WORD = 4'h3,
    SILD_LOAD_BYTE = 4'h4,
    SILD_STORE_HALF = 4'h5,
    SILD_LOAD_HALF = 4'h6,
    SILD_LOAD_SBYTE = 4'h7,
    SILD_LOAD_SHALF = 4'h8
  } sild_op_t;
  typedef enum logic [1:0] {
    SILD_IDLE = 2'b00,
    SILD_ACCESS = 2'b01,
    SILD_WRITEBACK = 2'b11
  } sild_state_t;
endpackage
